// >>> ddr2_cmd_decode.sv
// command, bank and clock-enable state decoder of the memory device
`timescale 1ns/10ps
module ddr2_cmd_decode
	import ddr2_cmd_pkg::*;
#(
	parameter bit WIDE16 = 1'b0
)(
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire logic                           cke,
	input  wire logic                           csN,
	input  wire logic                           rasN,
	input  wire logic                           casN,
	input  wire logic                           weN,
	input  wire logic [ddr2_cmd_pkg::BANK_W-1:0] bankAddr,
	input  wire logic [ddr2_cmd_pkg::ADDR_W-1:0] addr,
	input  wire logic [ddr2_cmd_pkg::MASK_W-1:0] dataMask,
	input  wire logic                           termIn,
	input  wire logic                           termEnable,
	output logic [2:0]                          cmdOp,
	output logic                                cmdValid,
	output logic [ddr2_cmd_pkg::BANK_W-1:0]      cmdBank,
	output logic [ddr2_cmd_pkg::ADDR_W-1:0]      cmdAddr,
	output logic                                cmdAutoPre,
	output logic                                precAll,
	output logic [ddr2_cmd_pkg::BANKS-1:0]       bankOpen,
	output logic [ddr2_cmd_pkg::MASK_W-1:0]      byteWriteEn,
	output logic                                burstBusy,
	output logic                                activePowerDown,
	output logic                                prechargePowerDown,
	output logic                                selfRefresh,
	output logic                                readAllowed,
	output logic                                termActive
);
	import ddr2_cmd_pkg::*;

	// registered state
	logic              ckePrev_q;
	power_t            pState_q, pState_d;
	logic [BANKS-1:0]  bankOpen_q, bankOpen_d;
	logic [BEAT_W-1:0] beat_q, beat_d;
	logic              burstAp_q, burstAp_d;
	logic [BANK_W-1:0] burstBank_q, burstBank_d;
	logic [XSRD_W-1:0] xsrd_q, xsrd_d;
	logic              srExitSeen_q;
	logic [2:0]        op_q;
	logic              valid_q, ap_q, all_q;
	logic [BANK_W-1:0] bank_q;
	logic [ADDR_W-1:0] addr_q;
	logic [MASK_W-1:0] wen_q;

	// strobe decode into an operation code
	function automatic op_t decodeOp(input logic [3:0] c);
		case (c)
			CMD_MODE_LOAD: decodeOp = OP_MODE_LOAD;
			CMD_REFRESH:   decodeOp = OP_REFRESH;
			CMD_PRECHARGE: decodeOp = OP_PRECHARGE;
			CMD_ACTIVATE:  decodeOp = OP_ACTIVATE;
			CMD_WRITE:     decodeOp = OP_WRITE;
			CMD_READ:      decodeOp = OP_READ;
			default:       decodeOp = OP_NONE;
		endcase
	endfunction

	// edge-sampled command; termination inputs take no part here
	wire logic [3:0] strobes  = {csN, rasN, casN, weN};
	wire op_t        opNow    = decodeOp(strobes);
	wire logic       bothHigh = ckePrev_q & cke;
	wire logic       ckeFall  = ckePrev_q & ~cke;
	wire logic       ckeRise  = ~ckePrev_q & cke;
	wire logic       nopLike  = (opNow == OP_NONE);
	wire logic       allIdle  = (bankOpen_q == '0) && (beat_q == '0);
	wire logic       apBit    = addr[AP_BIT];
	wire logic       rwCmd    = (opNow == OP_READ) || (opNow == OP_WRITE);
	wire logic       accept   = bothHigh && (pState_q == PS_IDLE || pState_q == PS_ACTIVE)
	                            && !nopLike;
	// x16 parts treat the top column bit as don't care
	wire logic       maskA9   = WIDE16 && rwCmd;
	wire logic [ADDR_W-1:0] addrUse = maskA9 ? (addr & ~(ADDR_W'(1) << COL_TOP_BIT)) : addr;
	wire logic       burstEnd = (beat_q == BEAT_W'(1));

	// self-refresh exit watcher: set by a cke rise, no clk needed;
	// held clear outside self-refresh so a stale catch cannot end the next stay
	wire logic       srClear  = rst || (pState_q != PS_SELF_REFRESH);
	always_ff @(posedge cke or posedge srClear)
	begin
		if (srClear)
			srExitSeen_q <= 1'b0;
		else
			srExitSeen_q <= 1'b1;
	end

	// power state, bank and burst bookkeeping
	always_comb
	begin
		pState_d    = pState_q;
		bankOpen_d  = bankOpen_q;
		beat_d      = beat_q;
		burstAp_d   = burstAp_q;
		burstBank_d = burstBank_q;
		xsrd_d      = (xsrd_q != '0) ? xsrd_q - XSRD_W'(1) : xsrd_q;
		// burst countdown; auto-precharge closes the row at the end
		if (beat_q != '0)
		begin
			beat_d = beat_q - BEAT_W'(1);
			if (burstEnd && burstAp_q)
				bankOpen_d[burstBank_q] = 1'b0;
		end
		case (pState_q)
			PS_IDLE, PS_ACTIVE:
			begin
				if (ckeFall && opNow == OP_REFRESH && allIdle)
					pState_d = PS_SELF_REFRESH;
				else if (ckeFall && nopLike)
					pState_d = (bankOpen_q != '0) ? PS_ACT_PD : PS_PRE_PD;
				else if (accept)
				begin
					case (opNow)
						OP_ACTIVATE: bankOpen_d[bankAddr] = 1'b1;
						OP_PRECHARGE:
						begin
							if (apBit)
								bankOpen_d = '0;
							else
								bankOpen_d[bankAddr] = 1'b0;
						end
						OP_READ, OP_WRITE:
						begin
							// a new access cannot cut a running four-beat burst
							if (beat_q == '0 || burstEnd)
							begin
								beat_d      = BEAT_W'(BURST_LEN / 2);
								burstAp_d   = apBit;
								burstBank_d = bankAddr;
							end
						end
						default: ;
					endcase
				end
				if (pState_d == PS_IDLE || pState_d == PS_ACTIVE)
					pState_d = (bankOpen_d != '0) ? PS_ACTIVE : PS_IDLE;
			end
			PS_PRE_PD:
				if (ckeRise) pState_d = PS_IDLE;
			PS_ACT_PD:
				if (ckeRise) pState_d = PS_ACTIVE;
			PS_SELF_REFRESH:
			begin
				if (srExitSeen_q || ckeRise)
				begin
					pState_d = PS_IDLE;
					xsrd_d   = XSRD_W'(XSRD_CLOCKS);
				end
			end
			default: pState_d = PS_IDLE;
		endcase
	end

	// state registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ckePrev_q   <= 1'b0;
			pState_q    <= PS_IDLE;
			bankOpen_q  <= '0;
			beat_q      <= '0;
			burstAp_q   <= 1'b0;
			burstBank_q <= '0;
			xsrd_q      <= '0;
		end
		else
		begin
			ckePrev_q   <= cke;
			pState_q    <= pState_d;
			bankOpen_q  <= bankOpen_d;
			beat_q      <= beat_d;
			burstAp_q   <= burstAp_d;
			burstBank_q <= burstBank_d;
			xsrd_q      <= xsrd_d;
		end
	end

	// registered command outputs and byte write enables
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			op_q    <= 3'h0;
			valid_q <= 1'b0;
			ap_q    <= 1'b0;
			all_q   <= 1'b0;
			bank_q  <= '0;
			addr_q  <= '0;
			wen_q   <= '0;
		end
		else
		begin
			op_q    <= accept ? 3'(opNow) : 3'h0;
			valid_q <= accept;
			ap_q    <= accept && rwCmd && apBit;
			all_q   <= accept && (opNow == OP_PRECHARGE) && apBit;
			bank_q  <= bankAddr;
			addr_q  <= addrUse;
			wen_q   <= (beat_q != '0 || (accept && opNow == OP_WRITE)) ? ~dataMask : '0;
		end
	end

	// output drive
	assign cmdOp              = op_q;
	assign cmdValid           = valid_q;
	assign cmdBank            = bank_q;
	assign cmdAddr            = addr_q;
	assign cmdAutoPre         = ap_q;
	assign precAll            = all_q;
	assign bankOpen           = bankOpen_q;
	assign byteWriteEn        = wen_q;
	assign burstBusy          = (beat_q != '0);
	assign activePowerDown    = (pState_q == PS_ACT_PD);
	assign prechargePowerDown = (pState_q == PS_PRE_PD);
	assign selfRefresh        = (pState_q == PS_SELF_REFRESH);
	assign readAllowed        = (xsrd_q == '0) && (pState_q != PS_SELF_REFRESH);
	assign termActive         = termEnable && termIn && (pState_q != PS_SELF_REFRESH);
endmodule

// >>> ddr2_cmd_decode_props.sv
// concurrent checks on the command and power-state decoder
`timescale 1ns/10ps
module ddr2_cmd_decode_props
	import ddr2_cmd_pkg::*;
(
	input wire logic	clk,
	input wire logic	rst,
	input wire logic	cke,
	input wire logic	csN,
	input wire logic	rasN,
	input wire logic	casN,
	input wire logic	weN,
	input wire logic [1:0]	bankAddr,
	input wire logic [12:0]	addr,
	input wire logic [1:0]	dataMask,
	input wire logic [2:0]	cmdOp,
	input wire logic	cmdValid,
	input wire logic [1:0]	cmdBank,
	input wire logic	cmdAutoPre,
	input wire logic [3:0]	bankOpen,
	input wire logic [1:0]	byteWriteEn,
	input wire logic	activePowerDown,
	input wire logic	prechargePowerDown,
	input wire logic	selfRefresh,
	input wire logic	readAllowed
);
	// strobe pattern, one clock, reset disables
	wire logic [2:0]	strb = {rasN, casN, weN};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_cmd_cause: assert property (cmdValid |-> $past(cke && !csN && strb != 3'h7))
		else $error("command without strobes");
	chk_bank_follow: assert property (cmdValid |-> cmdBank == $past(bankAddr))
		else $error("bank select lost");
	chk_act_pd: assert property ($past(cke) && !cke && csN && |bankOpen |=> activePowerDown)
		else $error("no active power-down");
	chk_pre_pd: assert property ($past(cke) && !cke && csN && !bankOpen |=> prechargePowerDown)
		else $error("no precharge power-down");
	chk_sr_entry: assert property ($past(cke) && !cke && !csN && strb == 3'h1
		&& !bankOpen |=> selfRefresh)
		else $error("no self-refresh entry");
	chk_sr_exit: assert property (selfRefresh && $rose(cke) |=> !selfRefresh && !readAllowed)
		else $error("self-refresh exit missed");
	chk_write_mask: assert property (cmdValid && cmdOp == OP_WRITE
		|-> byteWriteEn == ~$past(dataMask))
		else $error("byte enables wrong");
	chk_auto_pre: assert property (cmdValid && (cmdOp == OP_READ || cmdOp == OP_WRITE)
		|-> cmdAutoPre == $past(addr[10]))
		else $error("auto-precharge wrong");
	// main scenarios reached
	cover property (cmdValid && cmdOp == OP_WRITE);
	cover property (activePowerDown);
	cover property ($fell(selfRefresh));
endmodule
bind ddr2_cmd_decode ddr2_cmd_decode_props i_props (.*);

// >>> ddr2_cmd_pkg.sv
// constants and types for the command and power-state decoder
package ddr2_cmd_pkg;
	localparam int BANKS          = 4;
	localparam int BANK_W         = 2;
	localparam int ADDR_W         = 13;
	localparam int AP_BIT         = 10;	// auto_precharge_select_bit position
	localparam int COL_TOP_BIT    = 9;	// ignored in x16 reads and writes
	localparam int BURST_LEN      = 4;	// burst_length with no interruption
	localparam int BEAT_W         = 3;
	localparam int MASK_W         = 2;
	localparam int XSRD_CLOCKS    = 200;	// self_refresh_exit_read_delay
	localparam int XSRD_W         = 8;
	localparam logic [3:0] CMD_MODE_LOAD = 4'h0;	// cs ras cas we
	localparam logic [3:0] CMD_REFRESH   = 4'h1;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
	localparam logic [3:0] CMD_WRITE     = 4'h4;
	localparam logic [3:0] CMD_READ      = 4'h5;
	localparam logic [3:0] CMD_NOP       = 4'h7;

	typedef enum logic [2:0] {
		OP_NONE, OP_MODE_LOAD, OP_REFRESH, OP_PRECHARGE,
		OP_ACTIVATE, OP_WRITE, OP_READ
	} op_t;

	typedef enum {
		PS_IDLE, PS_ACTIVE, PS_PRE_PD, PS_ACT_PD, PS_SELF_REFRESH
	} power_t;
endpackage

// >>> ddr2_ctrl_model.sv
// controller model driving command, address and clock-enable
`timescale 1ns/10ps
module ddr2_ctrl_model
	import ddr2_cmd_pkg::*;
(
	input wire logic	clk,
	output logic	cke,
	output logic	csN,
	output logic	rasN,
	output logic	casN,
	output logic	weN,
	output logic [1:0]	bankAddr,
	output logic [12:0]	addr,
	output logic [1:0]	dataMask
);
	// idle with cke high and a no-operation
	initial {cke, csN, rasN, casN, weN, bankAddr, addr, dataMask} = 22'h2E0000;
	// one command for one edge, then no-operation with cke held
	task automatic send(input logic k, input logic [3:0] c, input logic [1:0] b,
		input logic [12:0] a, input logic [1:0] m);
		@(posedge clk);
		cke <= k;
		{csN, rasN, casN, weN} <= c;
		bankAddr <= b;
		addr <= a;
		dataMask <= m;
		@(posedge clk);
		{csN, rasN, casN, weN} <= CMD_NOP;
		bankAddr <= ~b;	// stale bank and address lines do not keep their value
		addr <= ~a;
		#1;
	endtask
endmodule

// >>> testbench.sv
// self-checking bench for the command and power-state decoder
`timescale 1ns/10ps
module testbench;
	import ddr2_cmd_pkg::*;
	logic	clk, rst, termIn, termEnable, cke, csN, rasN, casN, weN;
	logic [1:0]	bankAddr, dataMask, cmdBank, byteWriteEn;
	logic [12:0]	addr, cmdAddr;
	logic [2:0]	cmdOp;
	logic [3:0]	bankOpen;
	logic	cmdValid, cmdAutoPre, precAll, burstBusy, activePowerDown;
	logic	prechargePowerDown, selfRefresh, readAllowed, termActive;
	int	err_count, cmp_count;
	ddr2_cmd_decode #(.WIDE16(1'b1)) i_ddr2_cmd_decode (.*);
	ddr2_ctrl_model i_ddr2_ctrl_model (.*);
	// compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic go(input logic k, input logic [3:0] c, input logic [1:0] b,
		input logic [12:0] a, input logic [1:0] m);
		i_ddr2_ctrl_model.send(k, c, b, a, m);
	endtask
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// command codes, bank select, mask, x16 column and auto-precharge
	task automatic t_decode;
		go(1'b1, CMD_MODE_LOAD, 2'h2, 13'h0, 2'h0);
		check("load op", cmdOp, OP_MODE_LOAD);
		check("load reg", cmdBank, 2'h2);
		go(1'b1, CMD_REFRESH, 2'h0, 13'h0, 2'h0);
		check("refresh op", cmdOp, OP_REFRESH);
		go(1'b1, CMD_ACTIVATE, 2'h1, 13'h1ABC, 2'h0);
		check("open", {cmdOp, bankOpen}, {OP_ACTIVATE, 4'h2});
		go(1'b1, CMD_READ, 2'h1, 13'h0201, 2'h0);
		check("read", {cmdValid, cmdOp, cmdAddr}, {1'b1, OP_READ, 13'h0001});
		check("busy", {burstBusy, cmdAutoPre}, 2'h2);
		go(1'b1, CMD_WRITE, 2'h1, 13'h0601, 2'h1);
		check("write", {cmdOp, cmdAutoPre, cmdAddr}, {OP_WRITE, 1'b1, 13'h0401});
		check("byte enables", byteWriteEn, 2'h2);
		repeat (4) go(1'b1, CMD_NOP, 2'h0, 13'h0, 2'h0);
		check("closed", {cmdValid, bankOpen}, 5'h00);
		$display("decode test done");
	endtask
	// active and precharge power-down, refused command inside
	task automatic t_powerdown;
		go(1'b1, CMD_ACTIVATE, 2'h0, 13'h0, 2'h0);
		go(1'b0, 4'h8, 2'h0, 13'h0, 2'h0);
		check("active pd", activePowerDown, 1'b1);
		go(1'b0, CMD_READ, 2'h0, 13'h0, 2'h0);
		check("refused", cmdValid, 1'b0);
		go(1'b1, CMD_NOP, 2'h0, 13'h0, 2'h0);
		check("pd exit", activePowerDown, 1'b0);
		go(1'b1, CMD_ACTIVATE, 2'h3, 13'h0, 2'h0);
		go(1'b1, CMD_PRECHARGE, 2'h3, 13'h0, 2'h0);
		check("one closed", {cmdOp, precAll, bankOpen}, {OP_PRECHARGE, 1'b0, 4'h1});
		go(1'b1, CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0);
		check("all closed", {precAll, bankOpen}, 5'h10);
		go(1'b1, CMD_NOP, 2'h0, 13'h0, 2'h0);
		go(1'b0, 4'h8, 2'h0, 13'h0, 2'h0);
		check("precharge pd", {prechargePowerDown, activePowerDown}, 2'h2);
		go(1'b0, CMD_NOP, 2'h0, 13'h0, 2'h0);
		repeat (3) go(1'b1, CMD_NOP, 2'h0, 13'h0, 2'h0);
		check("pre pd exit", prechargePowerDown, 1'b0);
		$display("power-down test done");
	endtask
	// self-refresh entry, termination off, exit and read gate
	task automatic t_selfref;
		go(1'b0, CMD_REFRESH, 2'h0, 13'h0, 2'h0);
		check("sr entry", {selfRefresh, termActive}, 2'h2);
		repeat (2) go(1'b0, CMD_NOP, 2'h0, 13'h0, 2'h0);
		go(1'b1, 4'h8, 2'h0, 13'h0, 2'h0);
		check("sr exit", {selfRefresh, readAllowed, termActive}, 3'h1);
		repeat (XSRD_CLOCKS - 1) @(posedge clk);
		#1;
		check("read held", readAllowed, 1'b0);
		@(posedge clk);
		#1;
		check("read free", readAllowed, 1'b1);
		$display("self-refresh test done");
	endtask
	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// watchdog well beyond the expected run
	initial
	begin
		#20000;
		err_count++;
		stop_test;
	end
	// reset then tests
	initial
	begin
		rst = 1'b1;
		termIn = 1'b1;
		termEnable = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		check("reset gate", {readAllowed, bankOpen}, 5'h10);
		go(1'b1, CMD_NOP, 2'h0, 13'h0, 2'h0);
		t_decode;
		t_powerdown;
		t_selfref;
		stop_test;
	end
endmodule
